// ---- oag_regs.vh ----
`ifndef OAG_REGS_VH
`define OAG_REGS_VH

// Addressing mode codes
`define OAG_MODE_W            4
`define OAG_MODE_NONE         4'h0
`define OAG_MODE_DIRECT       4'h1
`define OAG_MODE_INDIRECT     4'h2
`define OAG_MODE_IMM8         4'h3
`define OAG_MODE_IMM16        4'h4
`define OAG_MODE_XDIRECT      4'h5
`define OAG_MODE_XINDIRECT    4'h6
`define OAG_MODE_CODE_PC      4'h7
`define OAG_MODE_CODE_DP      4'h8
`define OAG_MODE_RELATIVE     4'h9
`define OAG_MODE_PAGE         4'ha
`define OAG_MODE_LONG         4'hb
`define OAG_MODE_BIT          4'hc

// Address space boundaries
`define OAG_UPPER_BASE        8'h80
`define OAG_BIT_RAM_BASE      8'h20
`define OAG_BIT_RAM_LAST      8'h2f
`define OAG_PAGE_HI_W         5
`define OAG_PAGE_LO_W         11
`define OAG_BYTE_IDX_W        3

// Memory target select codes
`define OAG_TGT_W             3
`define OAG_TGT_NONE          3'h0
`define OAG_TGT_LOWER_RAM     3'h1
`define OAG_TGT_UPPER_RAM     3'h2
`define OAG_TGT_SFR           3'h3
`define OAG_TGT_EXT           3'h4
`define OAG_TGT_CODE          3'h5

`endif

// ---- oag_bit_map.v ----
`timescale 1ns/1ps
`include "oag_regs.vh"

// ---------------------------------------------
// Bit address to byte address and bit index
// ---------------------------------------------
module oag_bit_map (
    input  wire [7:0] bit_addr,   // Bit address operand
    output reg  [7:0] byte_addr,  // Containing byte address
    output reg  [2:0] bit_index,  // Bit within byte
    output reg        is_sfr,     // Byte lies in special registers
    output reg        valid       // Bit address maps to a legal byte
);
    always @* begin
        bit_index = bit_addr[2:0];
        if (bit_addr < `OAG_UPPER_BASE) begin
            // Low half: 16 bytes of bit RAM, eight bits each
            byte_addr = `OAG_BIT_RAM_BASE + {4'h0, bit_addr[6:3]};
            is_sfr    = 1'b0;
        end else begin
            // Special register whose base ends in 0h or 8h
            byte_addr = {bit_addr[7:3], 3'h0};
            is_sfr    = 1'b1;
        end
        valid = (byte_addr <= `OAG_BIT_RAM_LAST) || is_sfr;
    end
endmodule // oag_bit_map

// ---- oag_operand_addr.v ----
// Functional notes
// - Indirect mode addresses upper RAM 80h-FFh from pointer register 0 or 1
// - Indirect accesses never reach special registers; direct, eight-bit immediate and bit modes do
// - Direct address selects lower RAM below 80h, special registers above
// - Eight-bit immediate writes the first byte as data to the direct address in the second byte
// - Sixteen-bit immediate loads the data pointer from two following bytes
// - External direct moves use the data pointer as external address
// - External indirect through pointer registers is unsupported and refused
// - Indexed code read adds accumulator to PC or data pointer, result to accumulator
// - Relative branch adds signed offset byte to program counter
// - Page jump joins five upper next-address bits with eleven instruction bits
// - Far jump and call use two following bytes as target
// - Bit mode changes one bit only; valid for 20h-2Fh and aligned special registers
// - Special register bit n sits at bit address base plus n
`timescale 1ns/1ps
`include "oag_regs.vh"

module oag_operand_addr #(
    parameter ADDR_W = 16,                     // Program and external address width
    parameter DATA_W = 8                       // Data byte width
) (
    input  wire              core_clk,         // Core clock, 125 MHz
    input  wire              reset_n,          // Asynchronous reset, active low
    // Instruction fields
    input  wire              op_valid,         // Decoded instruction present
    input  wire [3:0]        op_mode,          // Addressing mode code
    input  wire              op_write,         // Operand is a destination
    input  wire              op_bit_value,     // Value for bit set or clear
    input  wire [DATA_W-1:0] op_byte1,         // First byte after opcode
    input  wire [DATA_W-1:0] op_byte2,         // Second byte after opcode
    input  wire [2:0]        op_page_bits,     // Opcode bits 7:5 for page jump
    // Core state
    input  wire              pointer_select,   // Choose pointer_register_1
    input  wire [DATA_W-1:0] pointer_register_0, // Pointer register 0 value
    input  wire [DATA_W-1:0] pointer_register_1, // Pointer register 1 value
    input  wire [DATA_W-1:0] accumulator,      // Accumulator value
    input  wire [ADDR_W-1:0] next_pc,          // Address of next instruction
    input  wire [DATA_W-1:0] code_rdata,       // Program memory read byte
    input  wire              code_rvalid,      // Program memory byte valid
    input  wire [DATA_W-1:0] bit_src_byte,     // Current byte for bit update
    // Memory side
    output reg  [ADDR_W-1:0] mem_addr,         // Selected operand address
    output reg  [2:0]        mem_target,       // Memory space select
    output reg               mem_write,        // Operand access is a write
    output reg  [DATA_W-1:0] mem_wdata,        // Immediate, accumulator or bit-merged data
    output reg  [2:0]        bit_index,        // Bit position for bit mode
    output reg               addr_valid,       // Address outputs valid, one cycle
    output reg               addr_error,       // Unsupported or invalid access
    // Pointer, branch and accumulator side
    output reg  [ADDR_W-1:0] data_pointer_16,  // Data pointer register
    output reg               data_pointer_16_load,        // Data pointer loaded, one cycle
    output reg  [ADDR_W-1:0] branch_target,    // Branch destination
    output reg               branch_valid,     // Branch target valid, one cycle
    output reg  [DATA_W-1:0] acc_wdata,        // New accumulator value
    output reg               acc_load          // Accumulator update, one cycle
);

    // ---------------------------------------------
    // State machine for indexed code read
    // ---------------------------------------------
    localparam ST_IDLE = 1'b0;
    localparam ST_CODE = 1'b1;

    reg              state_reg;
    reg              state_next;

    // ---------------------------------------------
    // Helpers
    // ---------------------------------------------
    // Address plus a byte, the byte signed or not
    function [ADDR_W-1:0] add_offset;
        input [ADDR_W-1:0] base;
        input [DATA_W-1:0] off;
        input              signed_off;
        begin
            if (signed_off)
                add_offset = base + {{(ADDR_W-DATA_W){off[DATA_W-1]}}, off};
            else
                add_offset = base + {{(ADDR_W-DATA_W){1'b0}}, off};
        end
    endfunction

    // Byte zero-extended to address width
    function [ADDR_W-1:0] widen;
        input [DATA_W-1:0] b;
        begin
            widen = {{(ADDR_W-DATA_W){1'b0}}, b};
        end
    endfunction

    // Direct space: lower RAM below 80h, special registers above
    function [`OAG_TGT_W-1:0] direct_space;
        input [DATA_W-1:0] a;
        begin
            direct_space = (a < `OAG_UPPER_BASE) ? `OAG_TGT_LOWER_RAM : `OAG_TGT_SFR;
        end
    endfunction

    // Two bytes joined, first byte high
    function [ADDR_W-1:0] join16;
        input [DATA_W-1:0] hi;
        input [DATA_W-1:0] lo;
        begin
            join16 = {hi, lo};
        end
    endfunction

    // ---------------------------------------------
    // Bit map
    // ---------------------------------------------
    wire [7:0] bm_byte;
    wire [2:0] bm_index;
    wire       bm_is_sfr;
    wire       bm_valid;

    oag_bit_map u_bit_map (
        .bit_addr  (op_byte1),
        .byte_addr (bm_byte),
        .bit_index (bm_index),
        .is_sfr    (bm_is_sfr),
        .valid     (bm_valid)
    );

    // ---------------------------------------------
    // Single-bit merge, other seven bits kept
    // ---------------------------------------------
    reg [DATA_W-1:0] bit_merged;
    always @* begin
        bit_merged = bit_src_byte;
        bit_merged[bm_index] = op_bit_value;
    end

    // ---------------------------------------------
    // Operand selects
    // ---------------------------------------------
    wire [DATA_W-1:0] ptr_val = pointer_select ? pointer_register_1 : pointer_register_0;
    wire              is_code = (op_mode == `OAG_MODE_CODE_PC) ||
                                (op_mode == `OAG_MODE_CODE_DP);
    wire              indirect_ok = (ptr_val >= `OAG_UPPER_BASE);

    // ---------------------------------------------
    // Code read sequencing
    // ---------------------------------------------
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (op_valid && is_code)
                    state_next = ST_CODE;
            end

            ST_CODE: begin
                if (code_rvalid)
                    state_next = ST_IDLE;
            end

            default: state_next = ST_IDLE;
        endcase
    end

    // ---------------------------------------------
    // State register
    // ---------------------------------------------
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ---------------------------------------------
    // Address generation
    // ---------------------------------------------
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_addr        <= {ADDR_W{1'b0}};
            mem_target      <= `OAG_TGT_NONE;
            mem_write       <= 1'b0;
            mem_wdata       <= {DATA_W{1'b0}};
            bit_index       <= 3'h0;

            addr_valid      <= 1'b0;
            addr_error      <= 1'b0;
            data_pointer_16 <= {ADDR_W{1'b0}};
            data_pointer_16_load       <= 1'b0;

            branch_target   <= {ADDR_W{1'b0}};
            branch_valid    <= 1'b0;

            acc_wdata       <= {DATA_W{1'b0}};
            acc_load        <= 1'b0;
        end else begin
            // Pulses fall back to zero unless a mode raises them
            addr_valid   <= 1'b0;
            addr_error   <= 1'b0;
            data_pointer_16_load    <= 1'b0;
            branch_valid <= 1'b0;
            acc_load     <= 1'b0;

            if (state_reg == ST_CODE) begin
                if (code_rvalid) begin
                    acc_wdata <= code_rdata;
                    acc_load  <= 1'b1;
                end
            end else if (op_valid) begin
                mem_write <= op_write;

                // Refused modes raise addr_error and never addr_valid
                case (op_mode)
                    `OAG_MODE_DIRECT: begin
                        mem_addr   <= widen(op_byte1);
                        mem_target <= direct_space(op_byte1);
                        addr_valid <= 1'b1;
                    end

                    `OAG_MODE_INDIRECT: begin
                        mem_addr <= widen(ptr_val);
                        if (indirect_ok) begin
                            mem_target <= `OAG_TGT_UPPER_RAM;
                            addr_valid <= 1'b1;
                        end else begin
                            mem_target <= `OAG_TGT_NONE;
                            addr_error <= 1'b1;
                        end
                    end

                    `OAG_MODE_IMM8: begin
                        mem_wdata  <= op_byte1;
                        mem_addr   <= widen(op_byte2);
                        mem_target <= direct_space(op_byte2);
                        mem_write  <= 1'b1;
                        addr_valid <= 1'b1;
                    end

                    `OAG_MODE_IMM16: begin
                        data_pointer_16 <= join16(op_byte1, op_byte2);
                        data_pointer_16_load       <= 1'b1;
                    end

                    `OAG_MODE_XDIRECT: begin
                        mem_addr   <= data_pointer_16;
                        mem_target <= `OAG_TGT_EXT;
                        mem_wdata  <= accumulator;
                        addr_valid <= 1'b1;
                    end

                    `OAG_MODE_XINDIRECT: begin
                        mem_target <= `OAG_TGT_NONE;
                        mem_write  <= 1'b0;
                        addr_error <= 1'b1;
                    end

                    `OAG_MODE_CODE_PC: begin
                        mem_addr   <= add_offset(next_pc, accumulator, 1'b0);
                        mem_target <= `OAG_TGT_CODE;
                        mem_write  <= 1'b0;
                        addr_valid <= 1'b1;
                    end

                    `OAG_MODE_CODE_DP: begin
                        mem_addr   <= add_offset(data_pointer_16, accumulator, 1'b0);
                        mem_target <= `OAG_TGT_CODE;
                        mem_write  <= 1'b0;
                        addr_valid <= 1'b1;
                    end

                    `OAG_MODE_RELATIVE: begin
                        branch_target <= add_offset(next_pc, op_byte1, 1'b1);
                        branch_valid  <= 1'b1;
                    end

                    `OAG_MODE_PAGE: begin
                        branch_target <= {next_pc[ADDR_W-1:`OAG_PAGE_LO_W],
                                          op_page_bits, op_byte1};
                        branch_valid  <= 1'b1;
                    end

                    `OAG_MODE_LONG: begin
                        branch_target <= join16(op_byte1, op_byte2);
                        branch_valid  <= 1'b1;
                    end

                    `OAG_MODE_BIT: begin
                        mem_addr   <= widen(bm_byte);
                        mem_target <= bm_is_sfr ? `OAG_TGT_SFR : `OAG_TGT_LOWER_RAM;
                        bit_index  <= bm_index;
                        mem_wdata  <= bit_merged;
                        addr_valid <= bm_valid;
                        addr_error <= ~bm_valid;
                    end

                    default: begin
                        mem_target <= `OAG_TGT_NONE;
                        mem_write  <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule // oag_operand_addr

// ---- oag_code_mem_model.sv ----
`timescale 1ns/1ps
`include "oag_regs.vh"
// --------------------------------------------
// Program memory answering indexed code reads
// --------------------------------------------
module oag_code_mem_model (
    input  wire        core_clk,    // Clock
    input  wire        reset_n,     // Reset, active low
    input  wire        slow,        // Four-cycle answer instead of one
    input  wire [15:0] mem_addr,    // Read address
    input  wire [2:0]  mem_target,  // Space select
    input  wire        addr_valid,  // Address strobe
    output reg  [7:0]  code_rdata,  // Read byte
    output reg         code_rvalid  // Read byte valid
);
    reg [2:0]  cnt_reg;
    reg [15:0] addr_reg;
    reg [7:0]  junk_reg;
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg     <= 3'h0;
            addr_reg    <= 16'h0000;
            junk_reg    <= 8'h00;
            code_rdata  <= 8'h00;
            code_rvalid <= 1'b0;
        end else begin
            // Data line churns outside answers
            junk_reg    <= junk_reg + 8'h35;
            code_rdata  <= junk_reg;
            code_rvalid <= 1'b0;
            if (addr_valid && mem_target == `OAG_TGT_CODE) begin
                cnt_reg  <= slow ? 3'h4 : 3'h1;
                addr_reg <= mem_addr;
            end else if (cnt_reg == 3'h1) begin
                code_rvalid <= 1'b1;
                code_rdata  <= addr_reg[7:0] ^ addr_reg[15:8] ^ 8'h3c;
                cnt_reg     <= 3'h0;
            end else if (cnt_reg != 3'h0) begin
                cnt_reg <= cnt_reg - 3'h1;
            end
        end
    end
endmodule // oag_code_mem_model

// ---- oag_operand_addr_checker.sv ----
`timescale 1ns/1ps
`include "oag_regs.vh"
// --------------------------------------------
// Address generation checks
// --------------------------------------------
module oag_operand_addr_checker (
    input wire        core_clk,           // Clock
    input wire        reset_n,            // Reset
    input wire        op_valid,           // Request
    input wire [3:0]  op_mode,            // Mode
    input wire [7:0]  op_byte1,           // Byte 1
    input wire [7:0]  op_byte2,           // Byte 2
    input wire [2:0]  op_page_bits,       // Page bits
    input wire        pointer_select,     // Pointer pick
    input wire [7:0]  pointer_register_0, // Pointer 0
    input wire [7:0]  pointer_register_1, // Pointer 1
    input wire [7:0]  accumulator,        // Index
    input wire [15:0] next_pc,            // Next address
    input wire [7:0]  code_rdata,         // Code byte
    input wire        code_rvalid,        // Code valid
    input wire [15:0] mem_addr,           // Address
    input wire [2:0]  mem_target,         // Space
    input wire [2:0]  bit_index,          // Bit position
    input wire        addr_valid,         // Address pulse
    input wire        addr_error,         // Refusal
    input wire [15:0] data_pointer_16,    // Pointer
    input wire        data_pointer_16_load,          // Pointer load
    input wire [15:0] branch_target,      // Target
    input wire        branch_valid,       // Target pulse
    input wire [7:0]  acc_wdata,          // New index
    input wire        acc_load            // Index load
);
    reg        busy_reg;
    wire       take     = op_valid && !busy_reg;
    wire [7:0] ptr      = pointer_select ? pointer_register_1 : pointer_register_0;
    wire [7:0] bit_byte = op_byte1[7] ? {op_byte1[7:3], 3'h0} : {4'h2, op_byte1[6:3]};
    wire [2:0] bit_pos  = op_byte1[2:0];
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_reg <= 1'b0;
        end else if (take && (op_mode == `OAG_MODE_CODE_PC || op_mode == `OAG_MODE_CODE_DP)) begin
            busy_reg <= 1'b1;
        end else if (code_rvalid) begin
            busy_reg <= 1'b0;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence s_fetch_issue;
        addr_valid && mem_target == `OAG_TGT_CODE;
    endsequence
    sequence s_fetch_done;
        acc_load && acc_wdata == $past(code_rdata);
    endsequence
    a_rel_target: assert property (take && op_mode == `OAG_MODE_RELATIVE |=>
        branch_valid && branch_target == $past(next_pc) + 16'($signed($past(op_byte1))))
        else $error("relative target wrong");
    a_page_target: assert property (take && op_mode == `OAG_MODE_PAGE |=> branch_valid &&
        branch_target == {$past(next_pc[15:11]), $past(op_page_bits), $past(op_byte1)})
        else $error("page target wrong");
    a_long_target: assert property (take && op_mode == `OAG_MODE_LONG |=>
        branch_valid && branch_target == {$past(op_byte1), $past(op_byte2)})
        else $error("long target wrong");
    a_data_pointer_16_load: assert property (take && op_mode == `OAG_MODE_IMM16 |=>
        data_pointer_16_load && data_pointer_16 == {$past(op_byte1), $past(op_byte2)})
        else $error("pointer load wrong");
    a_indirect_upper: assert property (take && op_mode == `OAG_MODE_INDIRECT && ptr[7] |=>
        addr_valid && mem_target == `OAG_TGT_UPPER_RAM && mem_addr == {8'h00, $past(ptr)})
        else $error("indirect access wrong");
    a_direct_split: assert property (take && op_mode == `OAG_MODE_DIRECT |=> addr_valid &&
        mem_target == ($past(op_byte1) >= 8'h80 ? `OAG_TGT_SFR : `OAG_TGT_LOWER_RAM))
        else $error("direct space wrong");
    a_xind_refused: assert property (take && op_mode == `OAG_MODE_XINDIRECT |=>
        addr_error && !addr_valid)
        else $error("external indirect accepted");
    a_xdirect_addr: assert property (take && op_mode == `OAG_MODE_XDIRECT |=> addr_valid &&
        mem_target == `OAG_TGT_EXT && mem_addr == data_pointer_16)
        else $error("external direct address wrong");
    a_code_issue: assert property (take && op_mode == `OAG_MODE_CODE_DP |=> s_fetch_issue ##0
        mem_addr == $past(data_pointer_16) + {8'h00, $past(accumulator)})
        else $error("code address wrong");
    a_code_done: assert property (busy_reg && code_rvalid |=> s_fetch_done)
        else $error("code byte not loaded");
    a_bit_place: assert property (take && op_mode == `OAG_MODE_BIT |=>
        mem_addr == {8'h00, $past(bit_byte)} && bit_index == $past(bit_pos))
        else $error("bit placement wrong");
endmodule // oag_operand_addr_checker

bind oag_operand_addr oag_operand_addr_checker u_chk (
    .core_clk(core_clk), .reset_n(reset_n), .op_valid(op_valid), .op_mode(op_mode),
    .op_byte1(op_byte1), .op_byte2(op_byte2), .op_page_bits(op_page_bits),
    .pointer_select(pointer_select), .pointer_register_0(pointer_register_0),
    .pointer_register_1(pointer_register_1), .accumulator(accumulator), .next_pc(next_pc),
    .code_rdata(code_rdata), .code_rvalid(code_rvalid), .mem_addr(mem_addr),
    .mem_target(mem_target), .addr_valid(addr_valid), .addr_error(addr_error),
    .data_pointer_16(data_pointer_16), .data_pointer_16_load(data_pointer_16_load), .branch_target(branch_target),
    .branch_valid(branch_valid), .acc_wdata(acc_wdata), .acc_load(acc_load),
    .bit_index(bit_index));

// ---- oag_operand_addr_tb.sv ----
`timescale 1ns/1ps
`include "oag_regs.vh"
// --------------------------------------------
// Scenario bench
// --------------------------------------------
module oag_operand_addr_tb;
    reg         core_clk, reset_n, op_valid, op_write, op_bit_value, pointer_select, slow;
    reg  [3:0]  op_mode;
    reg  [7:0]  op_byte1, op_byte2, pointer_register_0, pointer_register_1;
    reg  [7:0]  accumulator, bit_src_byte;
    reg  [2:0]  op_page_bits;
    reg  [15:0] next_pc;
    wire [7:0]  code_rdata, mem_wdata, acc_wdata;
    wire [15:0] mem_addr, data_pointer_16, branch_target;
    wire [2:0]  mem_target, bit_index;
    wire        code_rvalid, mem_write, addr_valid, addr_error, data_pointer_16_load, branch_valid, acc_load;
    integer     miscompares, checks_done, i;
    oag_operand_addr uut (.core_clk(core_clk), .reset_n(reset_n), .op_valid(op_valid),
        .op_mode(op_mode), .op_write(op_write), .op_bit_value(op_bit_value),
        .op_byte1(op_byte1), .op_byte2(op_byte2), .op_page_bits(op_page_bits),
        .pointer_select(pointer_select), .pointer_register_0(pointer_register_0),
        .pointer_register_1(pointer_register_1), .accumulator(accumulator), .next_pc(next_pc),
        .code_rdata(code_rdata), .code_rvalid(code_rvalid), .bit_src_byte(bit_src_byte),
        .mem_addr(mem_addr), .mem_target(mem_target), .mem_write(mem_write),
        .mem_wdata(mem_wdata), .bit_index(bit_index), .addr_valid(addr_valid),
        .addr_error(addr_error), .data_pointer_16(data_pointer_16), .data_pointer_16_load(data_pointer_16_load),
        .branch_target(branch_target), .branch_valid(branch_valid), .acc_wdata(acc_wdata),
        .acc_load(acc_load));
    oag_code_mem_model u_mem (.core_clk(core_clk), .reset_n(reset_n), .slow(slow),
        .mem_addr(mem_addr), .mem_target(mem_target), .addr_valid(addr_valid),
        .code_rdata(code_rdata), .code_rvalid(code_rvalid));
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", checks_done, miscompares);
            if (miscompares == 0 && checks_done > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task chk_val(input [15:0] got, input [15:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // Outputs stand at the negedge after the taking edge
    task issue(input [3:0] m, input [7:0] x, input [7:0] y);
        begin
            @(negedge core_clk);
            op_mode = m;
            op_byte1 = x;
            op_byte2 = y;
            op_valid = 1'b1;
            @(negedge core_clk);
            op_valid = 1'b0;
        end
    endtask
    task space(input [3:0] m, input [7:0] x, input [15:0] a, input [2:0] t);
        begin
            issue(m, x, 8'h30);
            chk_val({15'h0, addr_valid}, 16'h0001);
            chk_val(mem_addr, a);
            chk_val({13'h0, mem_target}, {13'h0, t});
        end
    endtask
    task code_case(input [3:0] m, input [15:0] a);
        begin
            space(m, 8'h00, a, `OAG_TGT_CODE);
            for (i = 0; i < 20 && acc_load !== 1'b1; i = i + 1)
                @(negedge core_clk);
            chk_val({15'h0, acc_load}, 16'h0001);
            chk_val({8'h00, acc_wdata}, {8'h00, a[7:0] ^ a[15:8] ^ 8'h3c});
        end
    endtask
    task branch(input [3:0] m, input [7:0] x, input [7:0] y, input [15:0] t);
        begin
            issue(m, x, y);
            chk_val({15'h0, branch_valid}, 16'h0001);
            chk_val(branch_target, t);
        end
    endtask
    task t_data;
        begin
            space(`OAG_MODE_DIRECT, 8'h7f, 16'h007f, `OAG_TGT_LOWER_RAM);
            space(`OAG_MODE_DIRECT, 8'h80, 16'h0080, `OAG_TGT_SFR);
            space(`OAG_MODE_INDIRECT, 8'h00, 16'h0080, `OAG_TGT_UPPER_RAM);
            pointer_select = 1'b1;
            space(`OAG_MODE_INDIRECT, 8'h00, 16'h00ff, `OAG_TGT_UPPER_RAM);
            issue(`OAG_MODE_IMM8, 8'h5a, 8'h30);
            chk_val({mem_write, 7'h0, mem_wdata}, 16'h805a);
            issue(`OAG_MODE_IMM16, 8'h12, 8'h34);
            chk_val(data_pointer_16, 16'h1234);
            chk_val({15'h0, data_pointer_16_load}, 16'h0001);
            space(`OAG_MODE_XDIRECT, 8'h00, 16'h1234, `OAG_TGT_EXT);
            chk_val({mem_write, 7'h0, mem_wdata}, 16'h80c3);
            op_write = 1'b0;
            space(`OAG_MODE_XDIRECT, 8'h00, 16'h1234, `OAG_TGT_EXT);
            chk_val({15'h0, mem_write}, 16'h0000);
            issue(`OAG_MODE_XINDIRECT, 8'h00, 8'h00);
            chk_val({14'h0, addr_error, addr_valid}, 16'h0002);
            pointer_register_1 = 8'h7f;
            issue(`OAG_MODE_INDIRECT, 8'h00, 8'h00);
            chk_val({11'h0, mem_target, addr_error, addr_valid}, 16'h0002);
        end
    endtask
    task t_flow;
        begin
            code_case(`OAG_MODE_CODE_DP, 16'h12f7);
            slow = 1'b0;
            next_pc = 16'h20ff;
            code_case(`OAG_MODE_CODE_PC, 16'h21c2);
            next_pc = 16'h1002;
            branch(`OAG_MODE_RELATIVE, 8'hfe, 8'h00, 16'h1000);
            branch(`OAG_MODE_RELATIVE, 8'h7f, 8'h00, 16'h1081);
            branch(`OAG_MODE_RELATIVE, 8'h80, 8'h00, 16'h0f82);
            next_pc = 16'h47ff;
            branch(`OAG_MODE_PAGE, 8'h00, 8'h00, 16'h4500);
            branch(`OAG_MODE_LONG, 8'h05, 8'h00, 16'h0500);
        end
    endtask
    task t_bit;
        begin
            space(`OAG_MODE_BIT, 8'haf, 16'h00a8, `OAG_TGT_SFR);
            chk_val({5'h0, bit_index, mem_wdata}, 16'h07d5);
            op_bit_value = 1'b0;
            bit_src_byte = 8'hff;
            space(`OAG_MODE_BIT, 8'h7a, 16'h002f, `OAG_TGT_LOWER_RAM);
            chk_val({5'h0, bit_index, mem_wdata}, 16'h02fb);
        end
    endtask
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        #200000;
        miscompares = miscompares + 1;
        complete_run;
    end
    initial begin
        miscompares = 0;
        checks_done = 0;
        {reset_n, op_valid, pointer_select, op_mode, op_byte1, op_byte2} = 0;
        {op_write, op_bit_value, slow, op_page_bits} = 6'h3d;
        pointer_register_0 = 8'h80;
        pointer_register_1 = 8'hff;
        accumulator = 8'hc3;
        bit_src_byte = 8'h55;
        next_pc = 16'h0000;
        repeat (10) @(negedge core_clk);
        reset_n = 1'b1;
        t_data;
        t_flow;
        t_bit;
        complete_run;
    end
endmodule // oag_operand_addr_tb
